// ===== logic/mubi_top.sv
// Operation
// - up to four channels, index zero upward
// - transmit empty status low while buffer holds data
// - transmit write sets full, word then sent
// - buffer empties when shifter takes the word
// - receive full status high while word unread
// - received character stored, full set by hardware
// - reading receive buffer returns word, empties it
// - buffer words sixteen bits, data in low bits
// - ten bit break sent and received
// - thirteen bit break sent and received
// - event vectors 0x77 down to 0x70
// - receive event on every received character
// - transmit event only on buffer handover
// - no repeat transmit event without refill
// - receive on even pin, transmit on odd
// - data bits per character from 1 to 14
// - events reach processor only when enabled
`timescale 1ns/1ps
module mubi_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // timer channel pins
  input  wire logic [7:0]  TIMER_PIN_I,
  output logic [7:0]       TIMER_PIN_O,
  output logic [7:0]       TIMER_PIN_OE,
  // event requests, bit k is vector 0x70 plus k
  output logic [7:0]       EVENT_REQ
);

  localparam int NCH = mubi_pkg::CHANNELS;

  // ****************************************
  // channel wiring
  // ****************************************
  logic [NCH-1:0] run;
  logic [NCH-1:0] tx_take;
  logic [NCH-1:0] tx_line;
  logic [NCH-1:0] rx_done;
  logic [15:0]    rx_word [NCH];
  logic [15:0]    tx_buf [NCH];
  logic [NCH-1:0] tx_full;
  logic [3:0]     nbits;
  logic           tick;

  // ****************************************
  // control registers
  // ****************************************
  logic        ctrl_en, next_ctrl_en;
  logic        ctrl_ev, next_ctrl_ev;
  logic [1:0]  ctrl_cnt, next_ctrl_cnt;
  logic [3:0]  ctrl_bits, next_ctrl_bits;
  logic [15:0] baud_div, next_baud_div;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic        next_tick;

  logic        setup;
  logic        wr_done;
  logic        rd_done;
  logic [1:0]  chan_sel;
  logic        in_tx;
  logic        in_rx;
  logic        mapped;

  assign setup    = PSEL && !PENABLE;
  // a refused access must leave every buffer and flag alone
  assign wr_done  = PSEL && PENABLE && PREADY && !PSLVERR && PWRITE;
  assign rd_done  = PSEL && PENABLE && PREADY && !PSLVERR && !PWRITE;
  assign chan_sel = PADDR[3:2];
  assign in_tx    = PADDR >= mubi_pkg::OFF_TX_BASE && PADDR < mubi_pkg::OFF_RX_BASE;
  assign in_rx    = PADDR >= mubi_pkg::OFF_RX_BASE && PADDR < mubi_pkg::OFF_RX_END;
  assign mapped   = PADDR[1:0] == 2'b00 && (PADDR <= mubi_pkg::OFF_EVENT || in_tx || in_rx);
  assign nbits    = mubi_pkg::clamp_bits(ctrl_bits);

  always_comb
  begin
    next_ctrl_en   = ctrl_en;
    next_ctrl_ev   = ctrl_ev;
    next_ctrl_cnt  = ctrl_cnt;
    next_ctrl_bits = ctrl_bits;
    next_baud_div  = baud_div;
    if (wr_done && PADDR == mubi_pkg::OFF_CTRL)
    begin
      next_ctrl_en   = PWDATA[mubi_pkg::CTRL_EN_BIT];
      next_ctrl_ev   = PWDATA[mubi_pkg::CTRL_EV_BIT];
      next_ctrl_cnt  = PWDATA[mubi_pkg::CTRL_CNT_LSB +: 2];
      next_ctrl_bits = PWDATA[mubi_pkg::CTRL_BITS_LSB +: 4];
    end
    if (wr_done && PADDR == mubi_pkg::OFF_BAUD)
      next_baud_div = PWDATA[15:0];
    // one enable pulse per sixteenth of a bit time
    next_tick     = tick_cnt >= baud_div;
    next_tick_cnt = next_tick ? 16'h0000 : tick_cnt + 16'h0001;
    if (!ctrl_en)
    begin
      next_tick     = 1'b0;
      next_tick_cnt = 16'h0000;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      ctrl_en   <= 1'b0;
      ctrl_ev   <= 1'b0;
      ctrl_cnt  <= mubi_pkg::CTRL_CNT_RST;
      ctrl_bits <= mubi_pkg::CTRL_BITS_RST;
      baud_div  <= mubi_pkg::BAUD_RST;
      tick_cnt  <= 16'h0000;
      tick      <= 1'b0;
    end
    else
    begin
      ctrl_en   <= next_ctrl_en;
      ctrl_ev   <= next_ctrl_ev;
      ctrl_cnt  <= next_ctrl_cnt;
      ctrl_bits <= next_ctrl_bits;
      baud_div  <= next_baud_div;
      tick_cnt  <= next_tick_cnt;
      tick      <= next_tick;
    end
  end

  // ****************************************
  // buffers and event flags
  // ****************************************
  logic [15:0]    rx_buf [NCH];
  logic [15:0]    next_tx_buf [NCH];
  logic [15:0]    next_rx_buf [NCH];
  logic [NCH-1:0] next_tx_full;
  logic [NCH-1:0] rx_full, next_rx_full;
  logic [NCH-1:0] rx_landed;
  logic [7:0]     events, next_events;

  always_comb
  begin
    next_events = events;
    // software clears first so that a new event in the same cycle wins
    if (wr_done && PADDR == mubi_pkg::OFF_EVENT)
      next_events = events & ~PWDATA[7:0];
    for (int i = 0; i < NCH; i++)
    begin
      run[i]          = ctrl_en && (2'(i) <= ctrl_cnt);
      next_tx_buf[i]  = tx_buf[i];
      next_tx_full[i] = tx_full[i];
      next_rx_buf[i]  = rx_buf[i];
      next_rx_full[i] = rx_full[i];
      if (tx_take[i])
      begin
        next_tx_full[i] = 1'b0;
        next_events[mubi_pkg::tx_ev_bit(2'(i))] = 1'b1;
      end
      if (wr_done && in_tx && chan_sel == 2'(i) && run[i])
      begin
        next_tx_buf[i]  = PWDATA[15:0];
        next_tx_full[i] = 1'b1;
      end
      // a character landing at the setup edge was not the one returned
      if (rd_done && in_rx && chan_sel == 2'(i) && !rx_done[i] && !rx_landed[i])
        next_rx_full[i] = 1'b0;
      if (rx_done[i])
      begin
        next_rx_buf[i]  = rx_word[i];
        next_rx_full[i] = 1'b1;
        next_events[mubi_pkg::rx_ev_bit(2'(i))] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        tx_buf[i] <= 16'h0000;
        rx_buf[i] <= 16'h0000;
      end
      tx_full   <= '0;
      rx_full   <= '0;
      rx_landed <= '0;
      events    <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        tx_buf[i] <= next_tx_buf[i];
        rx_buf[i] <= next_rx_buf[i];
      end
      tx_full   <= next_tx_full;
      rx_full   <= next_rx_full;
      rx_landed <= rx_done;
      events    <= next_events;
    end
  end

  // ****************************************
  // apb answer and pins
  // ****************************************
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  next_pin_o;
  logic [7:0]  next_pin_oe;
  logic [7:0]  next_event_req;

  always_comb
  begin
    // zero wait states: the answer is ready in the first access cycle
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    next_prdata  = PRDATA;
    if (setup && !PWRITE)
    begin
      next_prdata = 32'h0000_0000;
      case (PADDR)
        mubi_pkg::OFF_CTRL:
        begin
          next_prdata[mubi_pkg::CTRL_EN_BIT]         = ctrl_en;
          next_prdata[mubi_pkg::CTRL_EV_BIT]         = ctrl_ev;
          next_prdata[mubi_pkg::CTRL_CNT_LSB +: 2]   = ctrl_cnt;
          next_prdata[mubi_pkg::CTRL_BITS_LSB +: 4]  = ctrl_bits;
        end
        mubi_pkg::OFF_BAUD:
          next_prdata[15:0] = baud_div;
        mubi_pkg::OFF_STATUS:
        begin
          next_prdata[NCH-1:0] = ~tx_full & run;
          next_prdata[mubi_pkg::STAT_RX_LSB +: NCH] = rx_full;
        end
        mubi_pkg::OFF_EVENT:
          next_prdata[7:0] = events;
        default:
        begin
          if (in_rx && run[chan_sel])
            next_prdata[15:0] = rx_buf[chan_sel];
        end
      endcase
    end
    next_pin_o  = 8'h00;
    next_pin_oe = 8'h00;
    for (int i = 0; i < NCH; i++)
    begin
      next_pin_o[2*i+1]  = tx_line[i];
      next_pin_oe[2*i+1] = run[i];
    end
    next_event_req = ctrl_ev ? events : 8'h00;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      PRDATA       <= 32'h0000_0000;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      TIMER_PIN_O  <= 8'h00;
      TIMER_PIN_OE <= 8'h00;
      EVENT_REQ    <= 8'h00;
    end
    else
    begin
      PRDATA       <= next_prdata;
      PREADY       <= next_pready;
      PSLVERR      <= next_pslverr;
      TIMER_PIN_O  <= next_pin_o;
      TIMER_PIN_OE <= next_pin_oe;
      EVENT_REQ    <= next_event_req;
    end
  end

  // ****************************************
  // serial channels
  // ****************************************
  for (genvar g = 0; g < NCH; g++)
  begin : gen_chan
    mubi_chan u_chan (
      .clk     (MCLK),
      .rst_n   (RESETN),
      .run     (run[g]),
      .tick    (tick),
      .nbits   (nbits),
      .tx_full (tx_full[g]),
      .tx_word (tx_buf[g]),
      .tx_take (tx_take[g]),
      .tx_line (tx_line[g]),
      .rx_line (TIMER_PIN_I[2*g]),
      .rx_done (rx_done[g]),
      .rx_word (rx_word[g])
    );
  end

endmodule

// ===== logic/mubi_pkg.sv
package mubi_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CHANNELS = 4;
  localparam int WORD_W   = 16;
  localparam int DATA_MAX = 14;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_BAUD    = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_EVENT   = 8'h0C;
  localparam logic [7:0] OFF_TX_BASE = 8'h10;
  localparam logic [7:0] OFF_RX_BASE = 8'h20;
  localparam logic [7:0] OFF_RX_END  = 8'h30;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_EV_BIT   = 1;
  localparam int CTRL_CNT_LSB  = 2;
  localparam int CTRL_BITS_LSB = 4;
  localparam int STAT_RX_LSB   = 4;
  localparam int BREAK_FLAG    = 15;
  localparam logic [1:0]  CTRL_CNT_RST  = 2'h3;
  localparam logic [3:0]  CTRL_BITS_RST = 4'h8;
  localparam logic [15:0] BAUD_RST      = 16'h0516;

  // ****************************************
  // special words and event vectors
  // ****************************************
  localparam logic [15:0] BREAK_10 = 16'h800A;
  localparam logic [15:0] BREAK_13 = 16'h800D;
  localparam logic [7:0]  VEC_BASE = 8'h70;
  localparam logic [7:0]  VEC_RX0  = 8'h77;
  localparam logic [7:0]  VEC_TX0  = 8'h76;

  // ****************************************
  // sixteen ticks per bit, sample at the middle
  // ****************************************
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;

  typedef enum logic {MUBI_TX_IDLE, MUBI_TX_SEND} mubi_tx_state_t;
  typedef enum logic [1:0] {MUBI_RX_IDLE, MUBI_RX_START, MUBI_RX_DATA, MUBI_RX_BREAK}
    mubi_rx_state_t;

  function automatic logic [3:0] clamp_bits(input logic [3:0] n);
    if (n == 4'h0)
      return 4'h1;
    else if (n > 4'(DATA_MAX))
      return 4'(DATA_MAX);
    else
      return n;
  endfunction

  function automatic logic [15:0] data_mask(input logic [3:0] n);
    return 16'((17'h1 << n) - 17'h1);
  endfunction

  function automatic logic [2:0] rx_ev_bit(input logic [1:0] ch);
    return 3'(VEC_RX0 - VEC_BASE - {5'h0, ch, 1'b0});
  endfunction

  function automatic logic [2:0] tx_ev_bit(input logic [1:0] ch);
    return 3'(VEC_TX0 - VEC_BASE - {5'h0, ch, 1'b0});
  endfunction

endpackage

// ===== logic/mubi_chan.sv
`timescale 1ns/1ps
module mubi_chan (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [3:0]  nbits,
  // transmit holding buffer side
  input  wire logic        tx_full,
  input  wire logic [15:0] tx_word,
  output logic             tx_take,
  output logic             tx_line,
  // receive side
  input  wire logic        rx_line,
  output logic             rx_done,
  output logic [15:0]      rx_word
);

  // ****************************************
  // transmit shifter
  // ****************************************
  mubi_pkg::mubi_tx_state_t tx_state, next_tx_state;
  logic [15:0] tx_shift, next_tx_shift;
  logic [4:0]  tx_left, next_tx_left;
  logic [3:0]  tx_sub, next_tx_sub;
  logic        next_tx_line, next_tx_take;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_left  = tx_left;
    next_tx_sub   = tx_sub;
    next_tx_take  = 1'b0;
    case (tx_state)
      mubi_pkg::MUBI_TX_IDLE:
      begin
        if (tx_full && tick)
        begin
          next_tx_take  = 1'b1;
          next_tx_state = mubi_pkg::MUBI_TX_SEND;
          next_tx_sub   = 4'h0;
          if (tx_word[mubi_pkg::BREAK_FLAG])
          begin
            // break: low periods then one high stop
            next_tx_shift = 16'h1 << tx_word[3:0];
            next_tx_left  = {1'b0, tx_word[3:0]} + 5'h1;
          end
          else
          begin
            next_tx_shift = (16'h1 << ({1'b0, nbits} + 5'h1))
                          | ((tx_word & mubi_pkg::data_mask(nbits)) << 1);
            next_tx_left  = {1'b0, nbits} + 5'h2;
          end
        end
      end
      mubi_pkg::MUBI_TX_SEND:
      begin
        if (tick)
        begin
          next_tx_sub = tx_sub + 4'h1;
          if (tx_sub == mubi_pkg::SUB_LAST)
          begin
            next_tx_shift = tx_shift >> 1;
            next_tx_left  = tx_left - 5'h1;
            if (tx_left == 5'h1)
              next_tx_state = mubi_pkg::MUBI_TX_IDLE;
          end
        end
      end
      default: next_tx_state = mubi_pkg::MUBI_TX_IDLE;
    endcase
    if (!run)
    begin
      next_tx_state = mubi_pkg::MUBI_TX_IDLE;
      next_tx_take  = 1'b0;
    end
    next_tx_line = (next_tx_state == mubi_pkg::MUBI_TX_SEND) ? next_tx_shift[0] : 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_state <= mubi_pkg::MUBI_TX_IDLE;
      tx_shift <= 16'h0000;
      tx_left  <= 5'h00;
      tx_sub   <= 4'h0;
      tx_line  <= 1'b1;
      tx_take  <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_left  <= next_tx_left;
      tx_sub   <= next_tx_sub;
      tx_line  <= next_tx_line;
      tx_take  <= next_tx_take;
    end
  end

  // ****************************************
  // receive deserializer
  // ****************************************
  mubi_pkg::mubi_rx_state_t rx_state, next_rx_state;
  logic [13:0] rx_shift, next_rx_shift;
  logic [4:0]  rx_cnt, next_rx_cnt;
  logic [3:0]  rx_sub, next_rx_sub;
  logic        next_rx_done;
  logic [15:0] next_rx_word;

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt   = rx_cnt;
    next_rx_sub   = rx_sub;
    next_rx_done  = 1'b0;
    next_rx_word  = rx_word;
    if (tick)
      next_rx_sub = rx_sub + 4'h1;
    case (rx_state)
      mubi_pkg::MUBI_RX_IDLE:
      begin
        if (tick && !rx_line)
        begin
          next_rx_state = mubi_pkg::MUBI_RX_START;
          next_rx_sub   = 4'h0;
        end
      end
      mubi_pkg::MUBI_RX_START:
      begin
        // a glitch shorter than half a bit is not a start bit
        if (tick && rx_sub == mubi_pkg::SUB_MID)
        begin
          next_rx_state = rx_line ? mubi_pkg::MUBI_RX_IDLE : mubi_pkg::MUBI_RX_DATA;
          next_rx_sub   = 4'h0;
          next_rx_cnt   = 5'h00;
          next_rx_shift = 14'h0000;
        end
      end
      mubi_pkg::MUBI_RX_DATA:
      begin
        if (tick && rx_sub == mubi_pkg::SUB_LAST)
        begin
          if (rx_cnt < {1'b0, nbits})
          begin
            next_rx_shift[rx_cnt[3:0]] = rx_line;
            next_rx_cnt = rx_cnt + 5'h1;
          end
          else if (!rx_line && rx_shift == 14'h0000)
          begin
            next_rx_state = mubi_pkg::MUBI_RX_BREAK;
            next_rx_cnt   = {1'b0, nbits} + 5'h2;
          end
          else
          begin
            // a bad stop bit still delivers the data; low line is then left to idle
            next_rx_done  = 1'b1;
            next_rx_word  = {2'b00, rx_shift};
            next_rx_state = mubi_pkg::MUBI_RX_IDLE;
          end
        end
      end
      mubi_pkg::MUBI_RX_BREAK:
      begin
        if (tick && rx_sub == mubi_pkg::SUB_LAST)
        begin
          if (rx_line)
          begin
            next_rx_done  = 1'b1;
            next_rx_word  = {1'b1, 10'h000, rx_cnt};
            next_rx_state = mubi_pkg::MUBI_RX_IDLE;
          end
          else if (rx_cnt != 5'h1F)
            next_rx_cnt = rx_cnt + 5'h1;
        end
      end
      default: next_rx_state = mubi_pkg::MUBI_RX_IDLE;
    endcase
    if (!run)
    begin
      next_rx_state = mubi_pkg::MUBI_RX_IDLE;
      next_rx_done  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_state <= mubi_pkg::MUBI_RX_IDLE;
      rx_shift <= 14'h0000;
      rx_cnt   <= 5'h00;
      rx_sub   <= 4'h0;
      rx_done  <= 1'b0;
      rx_word  <= 16'h0000;
    end
    else
    begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt   <= next_rx_cnt;
      rx_sub   <= next_rx_sub;
      rx_done  <= next_rx_done;
      rx_word  <= next_rx_word;
    end
  end

endmodule

// ===== verif/mubi_properties.sv
`timescale 1ns/1ps
module mubi_properties (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RESETN,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins and events
  input wire logic [7:0]  TIMER_PIN_I,
  input wire logic [7:0]  TIMER_PIN_O,
  input wire logic [7:0]  TIMER_PIN_OE,
  input wire logic [7:0]  EVENT_REQ
);
  logic ev_en;
  logic next_ev_en;
  logic bad_adr;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  // ****************************************
  // shadow of the event enable bit
  // ****************************************
  assign bad_adr = PADDR >= mubi_pkg::OFF_RX_END || PADDR[1:0] != 2'h0;

  always_comb
  begin
    next_ev_en = ev_en;
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == mubi_pkg::OFF_CTRL)
      next_ev_en = PWDATA[mubi_pkg::CTRL_EV_BIT];
    if (!RESETN)
      next_ev_en = 1'b0;
  end

  always_ff @(posedge MCLK)
    ev_en <= next_ev_en;

  // ****************************************
  // assertions
  // ****************************************
  AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_BAD: assert property (PSEL && !PENABLE && bad_adr |=> PSLVERR && PREADY)
    else $error("unmapped address not refused");
  AST_ERR_GOOD: assert property (PSEL && !PENABLE && !bad_adr |=> !PSLVERR)
    else $error("mapped address refused");
  AST_WORD_16: assert property (PREADY && !PSLVERR && !PWRITE |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_EVEN_PINS: assert property ((TIMER_PIN_O & 8'h55) == 8'h00 && (TIMER_PIN_OE & 8'h55) == 8'h00)
    else $error("receive pin driven");
  AST_EVENT_GATE: assert property (!$past(ev_en) |-> EVENT_REQ == 8'h00)
    else $error("event raised while disabled");
  AST_EVENT_HOLD: assert property (($past(EVENT_REQ) & ~EVENT_REQ) != 8'h00 && $past(RESETN)
    |-> $past(PSEL && PENABLE && PWRITE, 2))
    else $error("event dropped without a write");
  AST_BIT_HOLD: assert property (TIMER_PIN_OE[1] && $past(TIMER_PIN_OE[1])
    && $changed(TIMER_PIN_O[1]) |=> ($stable(TIMER_PIN_O[1]) || !TIMER_PIN_OE[1])[*8])
    else $error("serial bit too short");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !RESETN
    |=> PREADY == 1'b0 && TIMER_PIN_OE == 8'h00 && EVENT_REQ == 8'h00)
    else $error("outputs active in reset");
endmodule

bind mubi_top mubi_properties u_props (
  .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_PIN_I(TIMER_PIN_I), .TIMER_PIN_O(TIMER_PIN_O), .TIMER_PIN_OE(TIMER_PIN_OE),
  .EVENT_REQ(EVENT_REQ));

// ===== verif/mubi_node.sv
`timescale 1ns/1ps
module mubi_node #(
  parameter int BIT = 16
) (
  // clock
  input  wire logic        clk,
  // device pins
  input  wire logic [7:0]  pin_o,
  input  wire logic [7:0]  pin_oe,
  output logic [7:0]       pin_i,
  // receive result
  input  wire logic [3:0]  nbits,
  output logic             got,
  output logic [15:0]      got_word
);
  logic [3:0] line;

  // a released transmit pin reads as the idle high level
  for (genvar c = 0; c < 4; c++)
  begin : g_line
    assign line[c] = pin_oe[2 * c + 1] ? pin_o[2 * c + 1] : 1'b1;
  end

  // static task: only the bench's main sequence calls it
  task drive(input int c, input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      pin_i[2 * c] <= v[i];
      repeat (BIT) @(posedge clk);
    end
    pin_i[2 * c] <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask

  // one frame at a time, lows past a low stop counted as a break
  initial
  begin : rx_side
    int c;
    int n;
    logic [15:0] w;
    logic brk;
    pin_i = 8'hFF;
    got = 1'b0;
    got_word = 16'h0000;
    c = 0;
    forever
    begin
      @(posedge clk);
      got <= 1'b0;
      if (line != 4'hF)
      begin
        for (int i = 0; i < 4; i++)
          if (!line[i])
            c = i;
        repeat (BIT / 2) @(posedge clk);
        w = 16'h0000;
        for (int i = 0; i < nbits; i++)
        begin
          repeat (BIT) @(posedge clk);
          w[i] = line[c];
        end
        repeat (BIT) @(posedge clk);
        brk = !line[c];
        n = nbits + 1;
        while (!line[c])
        begin
          n++;
          repeat (BIT) @(posedge clk);
        end
        got <= 1'b1;
        got_word <= brk ? 16'h8000 | 16'(n) : w;
      end
    end
  end
endmodule

// ===== verif/mubi_top_tb.sv
`timescale 1ns/1ps
module mubi_top_tb;
  logic        mclk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_i;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe;
  logic [7:0]  ev_req;
  logic        got;
  logic [15:0] got_word;
  logic [3:0]  nbits;
  logic [15:0] d;
  logic [15:0] m;
  logic [32:0] exp_q[$];
  int          error_cnt;
  int          checked;

  mubi_top uut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TIMER_PIN_I(pin_i), .TIMER_PIN_O(pin_o), .TIMER_PIN_OE(pin_oe),
    .EVENT_REQ(ev_req));
  mubi_node #(.BIT(16)) node (.clk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
    .nbits(nbits), .got(got), .got_word(got_word));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask

  // sent word must come out at the far side
  // the status read lands before the shifter can have emptied the buffer
  task automatic tx(input int c, input logic [15:0] w, input logic [15:0] want);
    exp_q.push_back({25'h0, 8'h0F & ~(8'h01 << c)});
    exp_q.push_back({17'h0, want});
    apb(1'b1, mubi_pkg::OFF_TX_BASE + 8'(4 * c), {16'h0, w});
    apb(1'b0, mubi_pkg::OFF_STATUS, 32'h0);
    while (exp_q.size() != 0)
      @(posedge mclk);
  endtask

  // reads and far-side words both retire the oldest note
  always @(posedge mclk)
  begin
    if (psel && penable && pready && !pwrite)
      check({pslverr, pslverr ? 32'h0 : prdata}, exp_q.pop_front());
    if (got)
      check({17'h0, got_word}, exp_q.pop_front());
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nbits = 4'h8;
    error_cnt = 0;
    checked = 0;
    void'($urandom(45630));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(mubi_pkg::OFF_CTRL, 33'h8C);
    rd(mubi_pkg::OFF_BAUD, 33'h516);
    rd(mubi_pkg::OFF_STATUS, 33'h0);
    rd(mubi_pkg::OFF_RX_END, 33'h100000000);
    rd(8'h02, 33'h100000000);
    apb(1'b1, mubi_pkg::OFF_BAUD, 32'h0);
    apb(1'b1, mubi_pkg::OFF_CTRL, 32'h8F);
    apb(1'b1, mubi_pkg::OFF_TX_BASE + 8'h1, 32'h55);
    rd(mubi_pkg::OFF_STATUS, 33'h0F);
    for (int c = 0; c < 4; c++)
    begin
      d = 16'($urandom) & 16'h00FF;
      tx(c, d, d);
      rd(mubi_pkg::OFF_STATUS, 33'h0F);
      rd(mubi_pkg::OFF_EVENT, {25'h0, 8'h40 >> (2 * c)});
      apb(1'b1, mubi_pkg::OFF_EVENT, 32'hFF);
      rd(mubi_pkg::OFF_EVENT, 33'h0);
      node.drive(c, {d[14:0], 1'b0}, 9);
      rd(mubi_pkg::OFF_STATUS, {25'h0, 8'h0F | (8'h10 << c)});
      rd(mubi_pkg::OFF_EVENT, {25'h0, 8'h80 >> (2 * c)});
      rd(mubi_pkg::OFF_RX_BASE + 8'(4 * c), {17'h0, d});
      rd(mubi_pkg::OFF_STATUS, 33'h0F);
      apb(1'b1, mubi_pkg::OFF_EVENT, 32'hFF);
    end
    tx(0, mubi_pkg::BREAK_10, mubi_pkg::BREAK_10);
    tx(1, mubi_pkg::BREAK_13, mubi_pkg::BREAK_13);
    node.drive(2, 16'h0000, 10);
    rd(mubi_pkg::OFF_RX_BASE + 8'h08, {17'h0, mubi_pkg::BREAK_10});
    node.drive(3, 16'h0000, 13);
    rd(mubi_pkg::OFF_RX_BASE + 8'h0C, {17'h0, mubi_pkg::BREAK_13});
    node.drive(1, 16'h00A2, 9);
    node.drive(1, 16'h01B4, 9);
    rd(mubi_pkg::OFF_RX_BASE + 8'h04, 33'h00DA);
    for (int k = 5; k <= 14; k += 9)
    begin
      nbits <= 4'(k);
      apb(1'b1, mubi_pkg::OFF_CTRL, 32'h0F | 32'(k << 4));
      m = 16'((1 << k) - 1);
      d = 16'($urandom) & 16'h7FFF;
      tx(0, d, d & m);
      node.drive(1, {d[14:0], 1'b0}, k + 1);
      rd(mubi_pkg::OFF_RX_BASE + 8'h04, {17'h0, d & m});
    end
    stop_test();
  end

  // the whole run needs well under a tenth of this
  initial
  begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule
